/* File: logic/stream_if.sv */
// valid/ready word stream between the serial engine and its fifo
`timescale 1ns/100ps
interface stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: logic/usart_core.sv */
// serial clock generation, frame transmitter and receiver
//
// What this block does
// - four clock modes; sync select picks async or sync operation
// - double speed acts only in async, never in sync mode choice
// - in sync mode pin direction picks master (out) or slave (in)
// - transfer clock pin used only in sync mode, idle otherwise
// - divisor counter runs on mclk, reloads at zero or low write
// - one baud pulse per zero, rate mclk over divisor plus one
// - transmitter divides baud pulses by 16, 8 or 2 per mode
// - receiver takes raw baud pulses, 16, 8 or 2 sample states
// - divisor is high and low parts, twelve bits, 0 to 4095
// - double speed receiver uses 8 samples per bit not 16
// - slave clock synchronised then edge detected, two cycle delay
// - sync data sampled on edge opposite to the change edge
// - polarity clear: change on rise, sample on fall; set swaps
// - one start, 5 to 9 data, none/even/odd parity, 1 or 2 stops
// - order: start, data lsb first, optional parity, stop bits
// - start low, stop high, line idles high between frames
// - one shared format setting for transmitter and receiver
// - receiver checks only first stop bit for framing error
// - parity is xor of data bits, inverted for odd parity
// - size field 7 means nine bits; ninth from separate bit
`timescale 1ns/100ps
`include "usart_params.svh"
module usart_core
  import usart_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // configuration
  input  wire logic        sync_mode_select,
  input  wire logic        double_speed_bit,
  input  wire logic        transfer_clock_pin_direction,
  input  wire logic        clock_polarity_select,
  input  wire logic [2:0]  char_size_field,
  input  wire logic [1:0]  parity_mode_field,
  input  wire logic        stop_count_select,
  input  wire logic [3:0]  baud_divisor_high,
  input  wire logic [7:0]  baud_divisor_low,
  input  wire logic        baud_divisor_low_wr,
  // transmit data
  input  wire logic [7:0]  tx_data,
  input  wire logic        ninth_transmit_bit,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  // receive data
  output logic [8:0]       rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic             rx_frame_error,
  output logic             rx_parity_error,
  // serial pins
  output logic             serial_out_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        transfer_clock_pin_in,
  output logic             transfer_clock_pin_out,
  output logic             transfer_clock_pin_oe
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] data_bits(input logic [2:0] sz);
    if (sz == `CHAR_NINE) begin
      data_bits = 4'h9;
    end else if (sz > 3'h3) begin
      data_bits = 4'h8;
    end else begin
      data_bits = 4'(4'h5 + {1'b0, sz});
    end
  endfunction

  function automatic logic parity_of(input logic [8:0] d,
                                     input logic [3:0] n,
                                     input logic       odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    parity_of = p;
  endfunction

  // ----------------------------------------------------------------
  // mode decode and shared frame format
  // ----------------------------------------------------------------
  clk_mode_t   mode;
  logic [3:0]  nbits;
  logic        par_en, par_odd;
  logic [4:0]  ovs;

  always_comb begin
    if (!sync_mode_select) begin
      mode = double_speed_bit ? MODE_ASYNC_2X : MODE_ASYNC;
    end else begin
      mode = transfer_clock_pin_direction ? MODE_SYNC_MASTER
                                          : MODE_SYNC_SLAVE;
    end
  end

  // one format feeds both directions, so a change hits both
  assign nbits   = data_bits(char_size_field);
  assign par_en  = parity_mode_field[1];
  assign par_odd = parity_mode_field[0];

  // samples per bit for async modes
  always_comb begin
    case (mode)
      MODE_ASYNC:    ovs = `OVS_NORMAL;
      MODE_ASYNC_2X: ovs = `OVS_DOUBLE;
      default:       ovs = `OVS_SYNC;
    endcase
  end

  // ----------------------------------------------------------------
  // baud rate generator
  // ----------------------------------------------------------------
  logic [`DIV_W-1:0] bcnt, next_bcnt;
  logic              baud_tick;
  logic [`DIV_W-1:0] divisor;

  assign divisor   = {baud_divisor_high, baud_divisor_low};
  assign baud_tick = (bcnt == '0);

  // reload on zero or a low-byte write
  always_comb begin
    if (baud_divisor_low_wr || baud_tick) begin
      next_bcnt = divisor;
    end else begin
      next_bcnt = `DIV_W'(bcnt - 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bcnt <= '0;
    end else begin
      bcnt <= next_bcnt;
    end
  end

  // ----------------------------------------------------------------
  // transfer clock: master output and slave input
  // ----------------------------------------------------------------
  logic xck_meta, xck_sync;
  logic xck_o, next_xck_o;
  logic xck_lvl, xck_lvl_d;
  logic x_rise, x_fall, x_change, x_sample;

  // master toggles on each baud tick: divide by two
  assign next_xck_o = (mode == MODE_SYNC_MASTER) ?
                      (baud_tick ? ~xck_o : xck_o) : 1'b0;

  // two-flop synchroniser, then edge detector
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      xck_meta  <= 1'b0;
      xck_sync  <= 1'b0;
      xck_o     <= 1'b0;
      xck_lvl_d <= 1'b0;
    end else begin
      xck_meta  <= transfer_clock_pin_in;
      xck_sync  <= xck_meta;
      xck_o     <= next_xck_o;
      xck_lvl_d <= xck_lvl;
    end
  end

  // pin is driven only as sync master, else released
  assign transfer_clock_pin_out = xck_o;
  assign transfer_clock_pin_oe  = (mode == MODE_SYNC_MASTER);

  // slave relies on a far clock below mclk/4
  assign xck_lvl  = (mode == MODE_SYNC_MASTER) ? xck_o :
                    (mode == MODE_SYNC_SLAVE)  ? xck_sync : 1'b0;
  assign x_rise   = xck_lvl & ~xck_lvl_d;
  assign x_fall   = ~xck_lvl & xck_lvl_d;
  // change and sample on opposite edges
  assign x_change = clock_polarity_select ? x_fall : x_rise;
  assign x_sample = clock_polarity_select ? x_rise : x_fall;

  // ----------------------------------------------------------------
  // serial input synchroniser
  // ----------------------------------------------------------------
  logic rxd_meta, rxd;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxd_meta <= 1'b1;
      rxd      <= 1'b1;
    end else begin
      rxd_meta <= serial_in_pin;
      rxd      <= rxd_meta;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  tx_state_t   tst, next_tst;
  logic [4:0]  tdiv, next_tdiv;
  logic [3:0]  tidx, next_tidx;
  logic [8:0]  tsh, next_tsh;
  logic        tout, next_tout;
  logic        tbit, tload, tsync;

  assign tsync = sync_mode_select;
  // one bit time ends on counter wrap or on a change edge
  assign tbit  = tsync ? x_change : (baud_tick && tdiv == 5'h01);
  assign tx_ready = (tst == TX_IDLE) || (tst == TX_STOP && tbit &&
                    (tidx == 4'h0 || !stop_count_select));
  assign tload = tx_valid & tx_ready;

  always_comb begin
    next_tst  = tst;
    next_tdiv = tdiv;
    next_tidx = tidx;
    next_tsh  = tsh;
    next_tout = tout;
    if (!tsync && baud_tick) begin
      next_tdiv = (tdiv == 5'h01) ? ovs : 5'(tdiv - 1'b1);
    end
    case (tst)
      TX_IDLE: begin
        next_tout = 1'b1;
      end
      TX_START: begin
        if (tbit && tsync && tout) begin
          next_tout = 1'b0;
        end else if (tbit) begin
          next_tst  = TX_DATA;
          next_tout = tsh[0];
          next_tidx = 4'h1;
        end
      end
      TX_DATA: begin
        if (tbit) begin
          if (tidx == nbits) begin
            next_tst  = par_en ? TX_PARITY : TX_STOP;
            next_tout = par_en ? parity_of(tsh, nbits, par_odd) : 1'b1;
            next_tidx = stop_count_select ? 4'h1 : 4'h0;
          end else begin
            next_tout = tsh[tidx];
            next_tidx = 4'(tidx + 1'b1);
          end
        end
      end
      TX_PARITY: begin
        if (tbit) begin
          next_tst  = TX_STOP;
          next_tout = 1'b1;
        end
      end
      TX_STOP: begin
        if (tbit) begin
          if (tidx != 4'h0 && stop_count_select) begin
            next_tidx = 4'h0;                        // second stop bit
          end else begin
            next_tst = TX_IDLE;
          end
        end
      end
      default: next_tst = TX_IDLE;
    endcase
    // a new frame may follow the last stop bit directly
    if (tload) begin
      next_tsh  = {ninth_transmit_bit & (nbits == 4'h9), tx_data};
      next_tst  = TX_START;
      next_tout = tsync;                             // sync starts on edge
      next_tdiv = ovs;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tst  <= TX_IDLE;
      tdiv <= `OVS_NORMAL;
      tidx <= '0;
      tsh  <= '0;
      tout <= 1'b1;
    end else begin
      tst  <= next_tst;
      tdiv <= next_tdiv;
      tidx <= next_tidx;
      tsh  <= next_tsh;
      tout <= next_tout;
    end
  end
  assign serial_out_pin = tout;

  // ----------------------------------------------------------------
  // receiver: sample counter on raw baud ticks
  // ----------------------------------------------------------------
  rx_state_t   rst_q, next_rst;
  logic [4:0]  rph, next_rph;
  logic [3:0]  ridx, next_ridx;
  logic [8:0]  rsh, next_rsh;
  logic        rpar, next_rpar;
  logic        rsamp, rmid;
  logic [10:0] out_word, next_out_word;
  logic        out_push, next_out_push;

  // mid-bit in async, sample edge in sync
  assign rmid  = baud_tick && (rph == {1'b0, ovs[4:1]});
  assign rsamp = tsync ? x_sample : rmid;

  always_comb begin
    next_rst      = rst_q;
    next_rph      = rph;
    next_ridx     = ridx;
    next_rsh      = rsh;
    next_rpar     = rpar;
    next_out_word = out_word;
    next_out_push = 1'b0;
    if (!tsync && baud_tick) begin
      next_rph = (rph == ovs) ? 5'h01 : 5'(rph + 1'b1);
    end
    case (rst_q)
      RX_IDLE: begin
        if (!rxd && (tsync ? x_sample : baud_tick)) begin
          next_rst  = tsync ? RX_DATA : RX_START;
          next_rph  = 5'h01;
          next_ridx = 4'h0;
          next_rsh  = '0;
        end
      end
      RX_START: begin
        if (rsamp) begin
          next_rst = rxd ? RX_IDLE : RX_DATA;        // false start reject
        end
      end
      RX_DATA: begin
        if (rsamp) begin
          next_rsh[ridx] = rxd;
          next_ridx      = 4'(ridx + 1'b1);
          if (4'(ridx + 1'b1) == nbits) begin
            next_rst = par_en ? RX_PARITY : RX_STOP;
          end
        end
      end
      RX_PARITY: begin
        if (rsamp) begin
          next_rpar = rxd;
          next_rst  = RX_STOP;
        end
      end
      RX_STOP: begin
        // only the first stop bit is looked at
        if (rsamp) begin
          next_out_word = {~rxd,
                           par_en & (rpar != parity_of(rsh, nbits, par_odd)),
                           rsh};
          next_out_push = 1'b1;
          next_rst      = RX_IDLE;
        end
      end
      default: next_rst = RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_q    <= RX_IDLE;
      rph      <= 5'h01;
      ridx     <= '0;
      rsh      <= '0;
      rpar     <= 1'b0;
      out_word <= '0;
      out_push <= 1'b0;
    end else begin
      rst_q    <= next_rst;
      rph      <= next_rph;
      ridx     <= next_ridx;
      rsh      <= next_rsh;
      rpar     <= next_rpar;
      out_word <= next_out_word;
      out_push <= next_out_push;
    end
  end

  // ----------------------------------------------------------------
  // receive fifo; a full fifo drops the word (overrun)
  // ----------------------------------------------------------------
  stream_if #(.W(11)) fin ();
  stream_if #(.W(11)) fout ();
  assign fin.valid = out_push;
  assign fin.data  = out_word;
  assign fout.ready = rx_ready;

  word_fifo #(.W(11), .D(`FIFO_DEPTH), .AW(`FIFO_AW)) word_fifo_i (
    .mclk (mclk),
    .nrst (nrst),
    .wr   (fin),
    .rd   (fout)
  );

  assign rx_valid        = fout.valid;
  assign rx_data         = fout.data[8:0];
  assign rx_parity_error = fout.data[9];
  assign rx_frame_error  = fout.data[10];
endmodule

/* File: logic/usart_params.svh */
// constants for the serial clock generator and frame engine
`ifndef USART_PARAMS_SVH
`define USART_PARAMS_SVH
`define DIV_W         12
`define DIV_MAX       12'hFFF
`define OVS_NORMAL    5'h10
`define OVS_DOUBLE    5'h08
`define OVS_SYNC      5'h02
`define CHAR_NINE     3'h7
`define PAR_EVEN      2'h2
`define PAR_ODD       2'h3
`define FIFO_DEPTH    16
`define FIFO_AW       4
`define DATA_W        9
`endif

/* File: logic/usart_pkg.sv */
// types shared by the serial engine files
package usart_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC,
    MODE_ASYNC_2X,
    MODE_SYNC_MASTER,
    MODE_SYNC_SLAVE
  } clk_mode_t;
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PARITY,
    TX_STOP
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rx_state_t;
endpackage

/* File: logic/word_fifo.sv */
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter int W  = 9,
  parameter int D  = 16,
  parameter int AW = 4
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // fill and drain sides
  stream_if.snk     wr,
  stream_if.src     rd
);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   cnt, next_cnt;
  logic          push, pop;

  // honest full and empty from the occupancy count
  assign wr.ready = (cnt != (AW+1)'(D));
  assign rd.valid = (cnt != '0);
  assign rd.data  = mem[rp];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // pointer and count next values
  always_comb begin
    next_wp  = push ? AW'(wp + 1'b1) : wp;
    next_rp  = pop  ? AW'(rp + 1'b1) : rp;
    next_cnt = cnt;
    if (push && !pop) begin
      next_cnt = (AW+1)'(cnt + 1'b1);
    end else if (pop && !push) begin
      next_cnt = (AW+1)'(cnt - 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage has no reset; contents are only read when counted valid
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp] <= wr.data;
    end
  end
endmodule

/* File: verif/serial_peer.sv */
// remote asynchronous transceiver facing the serial pins
`timescale 1ns/100ps
module serial_peer (
  // clock
  input wire logic mclk,
  // serial lines
  input wire logic line_in,
  output logic     line_out
);
  initial line_out = 1'b1;
  // frame image, bit 0 is the start bit; unused tail stays high
  function automatic logic [12:0] build(input logic [8:0] w,
    input int nb, input int par, input int ns, output int len);
    logic [12:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++)
      f[i + 1] = w[i];
    if (par >= 2)
      f[nb + 1] = ^(w & ((9'h1 << nb) - 9'h1)) ^ (par == 3);
    len = 1 + nb + (par >= 2) + ns;
    return f;
  endfunction
  // flip marks bits sent wrong on purpose; line rests high afterwards
  task automatic send(input logic [8:0] w, input int nb, input int par,
    input int ns, input logic [12:0] flip, input int bt);
    logic [12:0] f;
    int len;
    f = build(w, nb, par, ns, len) ^ flip;
    for (int i = 0; i < len; i++) begin
      @(posedge mclk);
      line_out <= f[i];
      repeat (bt - 1) @(posedge mclk);
    end
    @(posedge mclk);
    line_out <= 1'b1;
  endtask
  // mid-bit sampling; returns in the last bit so a next frame is not lost
  task automatic recv(input int len, input int bt, output logic [12:0] f);
    f = '1;
    while (line_in !== 1'b0)
      @(posedge mclk);
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < len; i++) begin
      f[i] = line_in;
      if (i < len - 1)
        repeat (bt) @(posedge mclk);
    end
  endtask
endmodule

/* File: verif/tb_usart_core.sv */
// self-checking bench for the serial clock and frame engine
`timescale 1ns/100ps
module tb_usart_core;
  logic       mclk, nrst, sync_mode_select, double_speed_bit, slave_run;
  logic       transfer_clock_pin_direction, clock_polarity_select;
  logic       stop_count_select, baud_divisor_low_wr, ninth_transmit_bit;
  logic       tx_valid, tx_ready, rx_valid, rx_ready, rx_frame_error;
  logic       rx_parity_error, serial_out_pin, serial_in_pin;
  logic       transfer_clock_pin_in, transfer_clock_pin_out;
  logic       transfer_clock_pin_oe;
  logic [2:0] char_size_field, xcnt;
  logic [1:0] parity_mode_field;
  logic [3:0] baud_divisor_high;
  logic [7:0] baud_divisor_low, tx_data;
  logic [8:0] rx_data;
  int         n_errors, n_tests, nb, npar, nst, bt;
  wire logic  xck = transfer_clock_pin_direction ? transfer_clock_pin_out
                                                 : transfer_clock_pin_in;
  usart_core usart_core_i (
    .mclk, .nrst, .sync_mode_select, .double_speed_bit,
    .transfer_clock_pin_direction, .clock_polarity_select,
    .char_size_field, .parity_mode_field, .stop_count_select,
    .baud_divisor_high, .baud_divisor_low, .baud_divisor_low_wr,
    .tx_data, .ninth_transmit_bit, .tx_valid, .tx_ready,
    .rx_data, .rx_valid, .rx_ready, .rx_frame_error, .rx_parity_error,
    .serial_out_pin, .serial_in_pin, .transfer_clock_pin_in,
    .transfer_clock_pin_out, .transfer_clock_pin_oe);
  serial_peer serial_peer_i (
    .mclk, .line_in(serial_out_pin), .line_out(serial_in_pin));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // slave clock of 16 mclk periods, still while no frame runs
  always @(posedge mclk) begin
    xcnt <= xcnt + 3'h1;
    if (slave_run && xcnt == 3'h7)
      transfer_clock_pin_in <= ~transfer_clock_pin_in;
  end
  task automatic check(input string what, input logic [12:0] exp,
    input logic [12:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // set a mode and format, reload the divisor, check the pin enable
  task automatic setup(input logic s, input logic d, input logic p,
    input logic x, input int sz, input int pm, input int st, input int dv);
    @(posedge mclk);
    {sync_mode_select, transfer_clock_pin_direction} <= {s, d};
    clock_polarity_select <= p;
    double_speed_bit <= x & ~s;
    {char_size_field, parity_mode_field} <= 5'({sz[2:0], pm[1:0]});
    stop_count_select <= st[0];
    {baud_divisor_high, baud_divisor_low} <= dv[11:0];
    baud_divisor_low_wr <= 1'b1;
    nb = sz < 4 ? sz + 5 : (sz == 7 ? 9 : 8);
    {npar, nst, bt} = {pm, st + 1, (dv + 1) * (x ? 8 : 16)};
    @(posedge mclk);
    baud_divisor_low_wr <= 1'b0;
    repeat (3) @(posedge mclk);
    check("pin enable", 13'(s & d), 13'(transfer_clock_pin_oe));
  endtask
  task automatic send_word(input logic [8:0] w);
    int n;
    n = 0;
    @(posedge mclk);
    {ninth_transmit_bit, tx_data, tx_valid} <= {w, 1'b1};
    do begin
      @(posedge mclk);
      n++;
    end while (tx_ready !== 1'b1 && n < 5000);
    if (n >= 5000)
      n_errors++;
    tx_valid <= 1'b0;
  endtask
  task automatic pop();
    @(posedge mclk);
    rx_ready <= 1'b1;
    @(posedge mclk);
    rx_ready <= 1'b0;
    @(posedge mclk);
  endtask
  // two frames back to back, both decoded by the peer
  task automatic tx_case(input int x, input int sz, input int pm,
    input int st, input int dv, input logic [8:0] w);
    logic [12:0] got;
    int len;
    setup(0, 0, 0, x, sz, pm, st, dv);
    fork
      begin
        send_word(w);
        send_word(~w);
      end
      begin
        serial_peer_i.recv(1 + nb + (npar >= 2) + nst, bt, got);
        check("tx frame", serial_peer_i.build(w, nb, npar, nst, len),
              got);
        serial_peer_i.recv(len, bt, got);
        check("tx frame", serial_peer_i.build(~w, nb, npar, nst, len),
              got);
      end
    join
  endtask
  task automatic rx_take(input logic [8:0] w, input logic pe,
    input logic fe);
    logic [12:0] m;
    int n;
    m = (13'h1 << nb) - 13'h1;
    n = 0;
    while (rx_valid !== 1'b1 && n < 800) begin
      @(posedge mclk);
      n++;
    end
    check("rx valid", 13'h1, 13'(rx_valid));
    check("rx word", 13'(w) & m, 13'(rx_data) & m);
    check("rx parity error", 13'(pe), 13'(rx_parity_error));
    check("rx frame error", 13'(fe), 13'(rx_frame_error));
    pop();
  endtask
  task automatic rx_case(input int x, input int sz, input int pm,
    input int st, input logic [8:0] w, input logic [12:0] flip,
    input logic pe, input logic fe);
    setup(0, 0, 0, x, sz, pm, st, 1);
    serial_peer_i.send(w, nb, npar, nst, flip, bt);
    rx_take(w, pe, fe);
  endtask
  // quiet line for a frame time, then discard whatever arrived
  task automatic flush();
    repeat (bt * 14) @(posedge mclk);
    while (rx_valid === 1'b1)
      pop();
  endtask
  // seventeen words into a sixteen word buffer, the last one dropped
  task automatic fifo_case();
    int n;
    setup(0, 0, 0, 0, 3, 0, 0, 0);
    for (int i = 0; i < 17; i++)
      serial_peer_i.send(9'(i), 8, 0, 1, 13'h0, bt);
    n = 0;
    while (rx_valid === 1'b1 && n < 20) begin
      check("fifo word", 13'(n), 13'(rx_data[7:0]));
      pop();
      n++;
    end
    check("fifo depth", 13'h10, 13'(n));
  endtask
  // sample the data pin on the sample edge of the transfer clock
  task automatic sync_case(input logic p, input logic m,
    input logic [8:0] w);
    logic [12:0] exp, got;
    logic xq;
    int n, k;
    setup(1, m, p, 0, 3, 0, 0, 2);
    exp = serial_peer_i.build(w, 8, 0, 1, n);
    got = 13'h1FFF;
    k = -1;
    n = 0;
    send_word(w);
    slave_run <= ~m;
    xq = xck;
    while (k < 9 && n < 4000) begin
      @(posedge mclk);
      n++;
      if (xck !== xq && xck === p && (k >= 0 || serial_out_pin === 1'b0)) begin
        k++;
        got[k] = serial_out_pin;
      end
      xq = xck;
    end
    repeat (48) @(posedge mclk);
    slave_run <= 1'b0;
    check("sync frame", exp, got);
  endtask
  initial begin
    nrst = 1'b0;
    {sync_mode_select, double_speed_bit, transfer_clock_pin_direction,
     clock_polarity_select, char_size_field, parity_mode_field,
     stop_count_select, baud_divisor_high, baud_divisor_low,
     baud_divisor_low_wr, tx_data, ninth_transmit_bit, tx_valid,
     rx_ready, transfer_clock_pin_in, slave_run, xcnt} = '0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    tx_case(0, 3, 0, 0, 1, 9'h0A5);
    tx_case(1, 0, 2, 1, 2, 9'h013);
    tx_case(0, 7, 3, 0, 0, 9'h1C6);
    tx_case(1, 5, 1, 1, 3, 9'h03C);
    tx_case(0, 2, 3, 1, 4, 9'h055);
    rx_case(0, 7, 3, 0, 9'h1A5, 13'h000, 0, 0);
    rx_case(1, 3, 2, 0, 9'h0C3, 13'h200, 1, 0);
    rx_case(0, 2, 0, 1, 9'h04B, 13'h200, 0, 0);
    rx_take(9'h07F, 0, 0);
    rx_case(0, 1, 1, 0, 9'h02D, 13'h080, 0, 1);
    flush();
    fifo_case();
    sync_case(0, 0, 9'h0B4);
    sync_case(1, 0, 9'h04D);
    sync_case(0, 1, 9'h0E1);
    sync_case(1, 1, 9'h036);
    give_verdict();
  end
  // cut a hang short well past the expected run length
  initial begin
    #(50 * 60000);
    n_errors++;
    give_verdict();
  end
endmodule
bind usart_core usart_core_props usart_core_props_i (
  .mclk, .nrst, .sync_mode_select, .double_speed_bit,
  .transfer_clock_pin_direction, .clock_polarity_select,
  .baud_divisor_high, .baud_divisor_low, .baud_divisor_low_wr,
  .tx_valid, .tx_ready, .serial_out_pin, .transfer_clock_pin_in,
  .transfer_clock_pin_out, .transfer_clock_pin_oe);

/* File: verif/usart_core_props.sv */
// assertion checker for the serial clock and frame engine
`timescale 1ns/100ps
module usart_core_props (
  // clock and reset
  input wire logic       mclk,
  input wire logic       nrst,
  // configuration
  input wire logic       sync_mode_select,
  input wire logic       double_speed_bit,
  input wire logic       transfer_clock_pin_direction,
  input wire logic       clock_polarity_select,
  input wire logic [3:0] baud_divisor_high,
  input wire logic [7:0] baud_divisor_low,
  input wire logic       baud_divisor_low_wr,
  // transmit side and pins
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       serial_out_pin,
  input wire logic       transfer_clock_pin_in,
  input wire logic       transfer_clock_pin_out,
  input wire logic       transfer_clock_pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic        master, take, tog_x, chg, out_q, xo_q, xi_q, st_run;
  logic [15:0] div1, bitlen, run, gap;
  logic [1:0]  tog;
  logic [7:0]  since;
  // derived conditions
  assign master = sync_mode_select & transfer_clock_pin_direction;
  assign take   = tx_valid & tx_ready;
  assign tog_x  = transfer_clock_pin_out ^ xo_q;
  assign chg    = clock_polarity_select ? xi_q & ~transfer_clock_pin_in
                                        : ~xi_q & transfer_clock_pin_in;
  assign div1   = {4'h0, baud_divisor_high, baud_divisor_low} + 16'h1;
  assign bitlen = double_speed_bit ? div1 << 3 : div1 << 4;
  // run lengths in mclk cycles; the first toggles after a reload are skipped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {xo_q, xi_q, st_run, tog, run, gap} <= '0;
      out_q <= 1'b1;
      since <= 8'hFF;
    end else begin
      out_q <= serial_out_pin;
      st_run <= take | (st_run & ~(serial_out_pin & ~out_q));
      xo_q  <= transfer_clock_pin_out;
      xi_q  <= transfer_clock_pin_in;
      run   <= (serial_out_pin ^ out_q) ? 16'h1 : run + 16'h1;
      gap   <= tog_x ? 16'h1 : gap + 16'h1;
      if (!master || baud_divisor_low_wr)
        tog <= 2'h0;
      else if (tog_x && tog != 2'h3)
        tog <= tog + 2'h1;
      since <= chg ? 8'h0 : (since == 8'hFF ? since : since + 8'h1);
    end
  end
  oe_async_a: assert property (
    !sync_mode_select |-> !transfer_clock_pin_oe)
    else $error("clock pin driven in async mode");
  oe_master_a: assert property (
    master |-> transfer_clock_pin_oe)
    else $error("clock pin not driven as master");
  oe_slave_a: assert property (
    sync_mode_select && !transfer_clock_pin_direction
      |-> !transfer_clock_pin_oe)
    else $error("clock pin driven as slave");
  start_bit_a: assert property (
    !sync_mode_select && take |=> !serial_out_pin && !tx_ready)
    else $error("no start bit after take");
  idle_high_a: assert property (
    tx_ready |-> serial_out_pin)
    else $error("line low while transmitter free");
  async_bit_a: assert property (
    !sync_mode_select && !st_run && $rose(serial_out_pin)
      |-> run % bitlen == 16'h0)
    else $error("async bit length wrong");
  master_clk_a: assert property (
    master && tog == 2'h3 && tog_x |-> gap == div1)
    else $error("master clock half period wrong");
  slave_delay_a: assert property (
    sync_mode_select && !transfer_clock_pin_direction
      && (serial_out_pin ^ out_q) && !$past(tx_ready)
      |-> since >= 8'h2 && since <= 8'h6)
    else $error("slave data change not after change edge");
  tx_async_c: cover property (!sync_mode_select && take);
  master_run_c: cover property (master && tog == 2'h3 && tog_x);
  slave_chg_c: cover property (sync_mode_select && chg);
endmodule
